// file: include/psm_pkg.sv
/*
   constants, register layout and state encoding of the power-mode sequencer.
   assumes a single 125 mhz ref_clk domain and the plain strobe register port.
*/
package psm_pkg;

   localparam int PSM_ADDR_W = 8;
   localparam int PSM_DATA_W = 32;

   // register offsets (byte addresses)
   localparam logic [7:0] PSM_CLK_STATUS_OFFSET = 8'h00;
   localparam logic [7:0] PSM_MODE_OFFSET = 8'h04;

   // clock_controller_status_reg fields
   localparam int PSM_SLOW_EN_POS = 0;
   localparam int PSM_SLOW_SEL_POS = 1;
   localparam int PSM_SLOW_SEL_W = 2;
   localparam int PSM_TB_IRQ_EN_POS = 3;
   localparam int PSM_LONG_DELAY_POS = 4;
   localparam int PSM_CTRL_W = 5;
   localparam logic [4:0] PSM_CTRL_RESET = 5'h00;

   // mode register field
   localparam int PSM_MODE_POS = 0;

   // oscillator settling, in core clock cycles
   localparam int PSM_SETTLE_SHORT = 256;
   localparam int PSM_SETTLE_LONG = 4096;
   localparam int PSM_SETTLE_W = 13;

   // interrupt mask value forced on entry to low-power modes
   localparam logic [1:0] PSM_MASK_ENABLE_ALL = 2'h2;

   // slow divider: ratio is 2 << select
   localparam int PSM_DIV_W = 4;

   typedef enum logic [7:0] {
      PSM_RUN = 8'h01,
      PSM_SLOW = 8'h02,
      PSM_WAIT = 8'h04,
      PSM_SLOW_WAIT = 8'h08,
      PSM_ACTIVE_HALT = 8'h10,
      PSM_HALT = 8'h20,
      PSM_SETTLE = 8'h40,
      PSM_HALT_REMAIN = 8'h80
   } psm_state_e;

   localparam logic [7:0] PSM_MODE_RESET = 8'h01;

endpackage : psm_pkg

// file: rtl/psm_slow_div.sv
/*
   core clock enable generator: one tick per cycle in full speed, one tick per
   2, 4, 8 or 16 cycles in slow operation.
   assumes the select field is stable while slow operation is on.
*/
module psm_slow_div #(
   parameter int DIV_W = psm_pkg::PSM_DIV_W
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic slow_on,
   input wire logic [1:0] slow_sel,
   output logic tick
);
   import psm_pkg::*;

   logic [DIV_W-1:0] cnt_reg;
   logic [DIV_W-1:0] cnt_next;
   logic [DIV_W-1:0] cnt_max;
   logic wrap;
   logic tick_reg;

   // ratio is 2 << sel, so the last count is that minus one
   assign cnt_max = DIV_W'((5'h02 << slow_sel) - 5'h01);
   assign wrap = (cnt_reg >= cnt_max);
   assign cnt_next = (!slow_on || wrap) ? '0 : cnt_reg + 1'b1;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_reg <= '0;
         tick_reg <= 1'b1;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= !slow_on || wrap;
      end
   end

   assign tick = tick_reg;

endmodule : psm_slow_div

// file: rtl/psm_settle.sv
/*
   delay counter for oscillator settling and for the post-wake window.
   assumes start is a one-cycle pulse; a new start restarts the count.
*/
module psm_settle #(
   parameter int CNT_W = psm_pkg::PSM_SETTLE_W
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic long_sel,
   input wire logic tick,
   output logic busy,
   output logic done
);
   import psm_pkg::*;

   localparam logic [CNT_W-1:0] SHORT_LOAD = CNT_W'(PSM_SETTLE_SHORT);
   localparam logic [CNT_W-1:0] LONG_LOAD = CNT_W'(PSM_SETTLE_LONG);

   logic [CNT_W-1:0] cnt_reg;
   logic busy_reg;
   logic done_reg;
   logic last;

   // counts core cycles, so slow operation stretches the window
   assign last = busy_reg && tick && (cnt_reg == CNT_W'(1));

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= last && !start;
         if (start) begin
            cnt_reg <= long_sel ? LONG_LOAD : SHORT_LOAD;
            busy_reg <= 1'b1;
         end else if (busy_reg && tick) begin
            cnt_reg <= cnt_reg - 1'b1;
            busy_reg <= !last;
         end
      end
   end

   assign busy = busy_reg;
   assign done = done_reg;

endmodule : psm_settle

// file: rtl/psm_power_mode_ctrl.sv
/*
   power-mode sequencer: run, slow, wait, slow-wait, active-halt and halt,
   clock enables for core, peripherals, oscillator and time base, mask forcing
   and wake-up with oscillator settling.
   assumes cpu and clock controller inputs are on ref_clk and that the cpu
   acts on the forced-mask, service and reset-vector pulses.
*/
// Summary of operation
// R1: reset starts run mode at master clock
// R2: slow enable and divider in status register
// R3: slow core clock is master over 2..16
// R4: wait in slow gives slow-wait, peripherals slow
// R5: wait stops cpu clock, peripherals keep running
// R6: wait entry forces interrupt mask to 10
// R7: wait ends on interrupt or reset, branch
// R8: halt picks active-halt when time-base enabled
// R9: active-halt forces mask, pending interrupt wakes
// R10: active-halt exits on time-base, capable irq, reset
// R11: interrupt exit from active-halt skips settling
// R12: active-halt keeps oscillator and time base only
// R13: active-halt with time-base suppresses watchdog reset
// R14: software keeps time-base enable through window
// R15: enable cleared in window drops to halt
// R16: push condition codes before servicing interrupt
// R17: full halt stops oscillator and all peripherals
// R18: halt exit restarts oscillator, waits settling delay
// R19: current mode visible as encoded output
// R20: reset in low-power returns to plain run
module psm_power_mode_ctrl (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [psm_pkg::PSM_ADDR_W-1:0] reg_addr,
   input wire logic [psm_pkg::PSM_DATA_W-1:0] reg_wr_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [psm_pkg::PSM_DATA_W-1:0] reg_rd_data,
   input wire logic wfi_exec,
   input wire logic halt_exec,
   input wire logic irq_pending,
   input wire logic time_base_irq,
   input wire logic active_halt_wake_irq,
   input wire logic halt_wake_irq,
   input wire logic reset_req,
   output logic core_clk_en,
   output logic periph_clk_en,
   output logic osc_enable,
   output logic time_base_clk_en,
   output logic mask_force,
   output logic [1:0] mask_force_value,
   output logic irq_service,
   output logic cc_push,
   output logic reset_vector_fetch,
   output logic watchdog_halt_block,
   output logic [7:0] mode_state
);
   import psm_pkg::*;

   logic [PSM_CTRL_W-1:0] ctrl_reg;
   logic [PSM_CTRL_W-1:0] ctrl_next;
   psm_state_e state_reg;
   psm_state_e state_next;
   logic wake_by_reset_reg;
   logic wake_by_reset_next;
   logic window_reg;
   logic window_next;
   logic settle_start;
   logic settle_busy;
   logic settle_done;
   logic core_tick;
   logic mask_force_next;
   logic irq_service_next;
   logic reset_fetch_next;
   logic [PSM_DATA_W-1:0] rd_next;
   logic core_clk_en_reg;
   logic periph_clk_en_reg;
   logic osc_enable_reg;
   logic time_base_clk_en_reg;
   logic mask_force_reg;
   logic [1:0] mask_value_reg;
   logic irq_service_reg;
   logic reset_fetch_reg;
   logic wdg_block_reg;
   logic [PSM_DATA_W-1:0] rd_data_reg;

   // register decode
   wire ctrl_hit = (reg_addr == PSM_CLK_STATUS_OFFSET);
   wire mode_hit = (reg_addr == PSM_MODE_OFFSET);
   wire slow_en = ctrl_reg[PSM_SLOW_EN_POS];
   wire [1:0] slow_sel = ctrl_reg[PSM_SLOW_SEL_POS +: PSM_SLOW_SEL_W];
   wire tb_irq_en = ctrl_reg[PSM_TB_IRQ_EN_POS];
   wire long_delay = ctrl_reg[PSM_LONG_DELAY_POS];
   wire window_open = window_reg && settle_busy;
   wire [PSM_DATA_W-1:0] ctrl_rd = {{(PSM_DATA_W-PSM_CTRL_W){1'b0}}, ctrl_reg};
   wire [PSM_DATA_W-1:0] mode_rd = {{(PSM_DATA_W-8){1'b0}}, state_reg} << PSM_MODE_POS;
   wire [PSM_DATA_W-1:0] rd_sel = ctrl_hit ? ctrl_rd : (mode_hit ? mode_rd : '0);
   // current-state decode
   wire in_slow = (state_reg == PSM_SLOW);
   wire in_slow_wait = (state_reg == PSM_SLOW_WAIT);
   wire slow_state = in_slow || in_slow_wait;
   wire resume_slow = slow_en;
   // next-state decode: enables are registered from it so they switch on the
   // same edge as mode_state; a lag would give the cpu one more clock after wfi
   wire next_run = (state_next == PSM_RUN);
   wire next_slow = (state_next == PSM_SLOW);
   wire next_active_halt = (state_next == PSM_ACTIVE_HALT);
   wire next_halt = (state_next == PSM_HALT);
   wire next_settle = (state_next == PSM_SETTLE);
   wire next_halt_remain = (state_next == PSM_HALT_REMAIN);
   wire cpu_halted = !next_run && !next_slow;
   wire periph_off = next_active_halt || next_halt || next_settle || next_halt_remain;
   wire osc_off = next_halt || next_halt_remain;
   // wake and write events, named once for the state machine
   wire ctrl_wr = reg_wr && ctrl_hit;
   wire ah_wake = time_base_irq || active_halt_wake_irq;
   wire halt_wake = reset_req || halt_wake_irq;
   wire window_drop = window_open && !tb_irq_en;
   wire [PSM_CTRL_W-1:0] slow_clear = ~(PSM_CTRL_W'(1) << PSM_SLOW_EN_POS);
   psm_state_e resume_state;

   assign resume_state = resume_slow ? PSM_SLOW : PSM_RUN;
   // a reset event also drops slow operation so the core comes back at full rate
   assign ctrl_next = reset_req ? (ctrl_reg & slow_clear) // see R20
                    : ctrl_wr ? reg_wr_data[PSM_CTRL_W-1:0] // see R2
                    : ctrl_reg;
   assign rd_next = reg_rd ? rd_sel : '0;

   psm_slow_div u_slow_div (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .slow_on(slow_state), // see R3
      .slow_sel(slow_sel),
      .tick(core_tick)
   );

   // one counter serves settling and the post-wake window, which never overlap
   psm_settle u_settle (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(settle_start),
      .long_sel(long_delay),
      .tick(core_tick),
      .busy(settle_busy),
      .done(settle_done)
   );

   // one step per edge; reset_req is tested first in every state
   always_comb begin
      state_next = state_reg;
      wake_by_reset_next = wake_by_reset_reg;
      window_next = window_reg && settle_busy;
      settle_start = 1'b0;
      mask_force_next = 1'b0;
      irq_service_next = 1'b0;
      reset_fetch_next = 1'b0;
      case (state_reg)
         PSM_RUN, PSM_SLOW: begin
            if (reset_req) begin
               state_next = PSM_RUN; // see R20
               reset_fetch_next = 1'b1;
               window_next = 1'b0;
            end else if (window_drop) begin
               state_next = PSM_HALT_REMAIN; // see R15
            end else if (halt_exec) begin
               mask_force_next = 1'b1; // see R9
               if (irq_pending) begin
                  irq_service_next = 1'b1; // see R9
               end else if (tb_irq_en) begin
                  state_next = PSM_ACTIVE_HALT; // see R8
               end else begin
                  state_next = PSM_HALT; // see R8
               end
            end else if (wfi_exec) begin
               mask_force_next = 1'b1; // see R6
               state_next = in_slow ? PSM_SLOW_WAIT : PSM_WAIT; // see R4
            end else begin
               state_next = slow_en ? PSM_SLOW : PSM_RUN; // see R2
            end
         end
         PSM_WAIT, PSM_SLOW_WAIT: begin
            if (reset_req) begin
               state_next = PSM_RUN; // see R7
               reset_fetch_next = 1'b1;
            end else if (irq_pending) begin
               state_next = in_slow_wait ? PSM_SLOW : PSM_RUN; // see R7
               irq_service_next = 1'b1;
            end
         end
         PSM_ACTIVE_HALT: begin
            if (reset_req) begin
               state_next = PSM_SETTLE; // see R11
               wake_by_reset_next = 1'b1;
               settle_start = 1'b1;
               window_next = 1'b0;
            end else if (ah_wake) begin
               // no settling: oscillator never stopped, but open the window
               state_next = resume_state; // see R10, R11
               irq_service_next = 1'b1;
               settle_start = 1'b1;
               window_next = 1'b1; // see R14
            end
         end
         PSM_HALT: begin
            if (halt_wake) begin
               state_next = PSM_SETTLE; // see R18
               wake_by_reset_next = reset_req;
               settle_start = 1'b1;
               window_next = 1'b0;
            end
         end
         PSM_HALT_REMAIN: begin
            if (reset_req) begin
               state_next = PSM_SETTLE; // see R20
               wake_by_reset_next = 1'b1;
               settle_start = 1'b1;
               window_next = 1'b0;
            end else if (settle_done || !settle_busy) begin
               state_next = resume_state; // see R15
               window_next = 1'b0;
            end
         end
         PSM_SETTLE: begin
            if (reset_req) begin
               wake_by_reset_next = 1'b1;
               settle_start = 1'b1;
            end else if (settle_done) begin
               state_next = wake_by_reset_reg ? PSM_RUN : resume_state; // see R18
               reset_fetch_next = wake_by_reset_reg; // see R20
               irq_service_next = !wake_by_reset_reg;
               wake_by_reset_next = 1'b0;
            end
         end
         default: begin
            state_next = PSM_RUN;
         end
      endcase
   end

   // gated clock enables and the watchdog block track the next state
   wire core_en_next = !cpu_halted && core_tick; // see R5
   wire periph_en_next = !periph_off && core_tick; // see R12, R17
   wire tb_en_next = !osc_off; // see R12, R17
   wire wdg_block_next = next_active_halt && tb_irq_en; // see R13

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl_reg <= PSM_CTRL_RESET; // see R1
         state_reg <= PSM_RUN; // see R1
         wake_by_reset_reg <= 1'b0;
         window_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         state_reg <= state_next;
         wake_by_reset_reg <= wake_by_reset_next;
         window_reg <= window_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         core_clk_en_reg <= 1'b1;
         periph_clk_en_reg <= 1'b1;
         osc_enable_reg <= 1'b1;
         time_base_clk_en_reg <= 1'b1;
         wdg_block_reg <= 1'b0;
      end else begin
         core_clk_en_reg <= core_en_next;
         periph_clk_en_reg <= periph_en_next;
         osc_enable_reg <= !osc_off; // see R17, R18
         time_base_clk_en_reg <= tb_en_next;
         wdg_block_reg <= wdg_block_next;
      end
   end

   // pulses and read data toward the cpu; the mask value is a constant flop so
   // that every output leaves a register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mask_force_reg <= 1'b0;
         mask_value_reg <= PSM_MASK_ENABLE_ALL;
         irq_service_reg <= 1'b0;
         reset_fetch_reg <= 1'b0;
         rd_data_reg <= '0;
      end else begin
         mask_force_reg <= mask_force_next;
         mask_value_reg <= PSM_MASK_ENABLE_ALL; // see R6, R9
         irq_service_reg <= irq_service_next; // see R16
         reset_fetch_reg <= reset_fetch_next;
         rd_data_reg <= rd_next;
      end
   end

   assign reg_rd_data = rd_data_reg;
   assign core_clk_en = core_clk_en_reg;
   assign periph_clk_en = periph_clk_en_reg;
   assign osc_enable = osc_enable_reg;
   assign time_base_clk_en = time_base_clk_en_reg;
   assign mask_force = mask_force_reg;
   assign mask_force_value = mask_value_reg; // see R6, R9
   assign irq_service = irq_service_reg;
   // the cpu stacks condition codes on the same pulse that starts service
   assign cc_push = irq_service_reg; // see R16
   assign reset_vector_fetch = reset_fetch_reg;
   assign watchdog_halt_block = wdg_block_reg;
   assign mode_state = state_reg; // see R19

endmodule : psm_power_mode_ctrl

// file: verification/psm_ctrl_assertions.sv
/* port checker of the power-mode sequencer.
   assumes one ref_clk domain; bound to psm_power_mode_ctrl below. */
module psm_ctrl_assertions (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic wfi_exec,
   input wire logic irq_pending,
   input wire logic time_base_irq,
   input wire logic active_halt_wake_irq,
   input wire logic halt_wake_irq,
   input wire logic reset_req,
   input wire logic core_clk_en,
   input wire logic periph_clk_en,
   input wire logic osc_enable,
   input wire logic time_base_clk_en,
   input wire logic mask_force,
   input wire logic [1:0] mask_force_value,
   input wire logic irq_service,
   input wire logic cc_push,
   input wire logic reset_vector_fetch,
   input wire logic [7:0] mode_state
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] settle_cnt;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   // cycles spent settling; cycles bound core ticks from above in slow too
   always_ff @(posedge ref_clk) begin
      if (sys_rst || mode_state != 8'h40) begin
         settle_cnt <= 16'h0000;
      end else begin
         settle_cnt <= settle_cnt + 16'h0001;
      end
   end
   sequence s_run_wfi;
      wfi_exec && mode_state == 8'h01 && !reset_req;
   endsequence
   sequence s_wait_in;
      mode_state == 8'h04 && mask_force && !core_clk_en;
   endsequence
   sequence s_resumed;
      irq_service && mode_state inside {8'h01, 8'h02};
   endsequence
   wait_entry_a: assert property (s_run_wfi |=> s_wait_in)
      else $error("wait entry wrong");
   wait_clocks_a: assert property (mode_state == 8'h04 |-> periph_clk_en && !core_clk_en)
      else $error("wait clocks wrong");
   ahalt_clocks_a: assert property (mode_state == 8'h10 |->
      osc_enable && time_base_clk_en && !periph_clk_en && !core_clk_en)
      else $error("active-halt clocks wrong");
   halt_off_a: assert property (mode_state == 8'h20 |-> !osc_enable && !periph_clk_en)
      else $error("halt clocks wrong");
   mask_value_a: assert property (mask_force |-> mask_force_value == 2'h2)
      else $error("forced mask wrong");
   push_pair_a: assert property (irq_service || cc_push |-> irq_service && cc_push)
      else $error("push without service");
   ahalt_wake_a: assert property (mode_state == 8'h10 && !reset_req &&
      (time_base_irq || active_halt_wake_irq) |=> s_resumed)
      else $error("active-halt wake wrong");
   wait_wake_a: assert property (mode_state == 8'h04 && irq_pending && !reset_req
      |=> s_resumed)
      else $error("wait wake wrong");
   reset_wake_a: assert property (mode_state inside {8'h04, 8'h08} && reset_req
      |=> mode_state == 8'h01 && reset_vector_fetch)
      else $error("reset wake wrong");
   halt_settle_a: assert property (mode_state == 8'h20 && halt_wake_irq
      |=> mode_state == 8'h40 && osc_enable)
      else $error("halt exit wrong");
   settle_len_a: assert property ($fell(mode_state == 8'h40) |-> settle_cnt >= 16'h00FF)
      else $error("settling too short");
endmodule : psm_ctrl_assertions

bind psm_power_mode_ctrl psm_ctrl_assertions psm_ctrl_assertions_inst (.ref_clk, .sys_rst,
   .wfi_exec, .irq_pending, .time_base_irq, .active_halt_wake_irq, .halt_wake_irq,
   .reset_req, .core_clk_en, .periph_clk_en, .osc_enable, .time_base_clk_en, .mask_force,
   .mask_force_value, .irq_service, .cc_push, .reset_vector_fetch, .mode_state);

// file: verification/psm_cpu_model.sv
/* cpu core model: issues wait and halt instruction pulses on request and
   keeps the condition code mask. assumes the ref_clk domain. */
module psm_cpu_model (
   input wire logic ref_clk,
   input wire logic mask_force,
   input wire logic [1:0] mask_force_value,
   input wire logic cc_push,
   input wire logic irq_service,
   input wire logic reset_vector_fetch,
   output logic wfi_exec,
   output logic halt_exec
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cc_mask = 2'h3;
   logic [1:0] stack_q[$];
   int svc_count = 0;
   int rst_count = 0;
   initial begin
      wfi_exec = 1'b0;
      halt_exec = 1'b0;
   end
   always @(posedge ref_clk) begin
      if (mask_force) cc_mask <= mask_force_value;
      if (cc_push) stack_q.push_back(cc_mask);
      if (irq_service) svc_count <= svc_count + 1;
      // reset routine starts with all interrupts masked
      if (reset_vector_fetch) cc_mask <= 2'h3;
      if (reset_vector_fetch) rst_count <= rst_count + 1;
   end
   task automatic exec(input logic halt);
      @(posedge ref_clk);
      wfi_exec <= !halt;
      halt_exec <= halt;
      @(posedge ref_clk);
      wfi_exec <= 1'b0;
      halt_exec <= 1'b0;
   endtask : exec
endmodule : psm_cpu_model

// file: verification/psm_power_mode_ctrl_bench.sv
/* self-checking bench of the power-mode sequencer.
   assumes the cpu model file and the bound checker are compiled before. */
module psm_power_mode_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wr_data = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [4:0] ev = 5'h00;
   logic [31:0] rd_q;
   logic wfi_exec, halt_exec, core_clk_en, periph_clk_en, osc_enable, tb_en;
   logic mask_force, irq_service, cc_push, rv_fetch, wd_block;
   logic [1:0] mask_val;
   logic [7:0] mode_state;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;
   int k;
   int exp_svc = 0;
   psm_power_mode_ctrl psm_power_mode_ctrl_inst (.ref_clk, .sys_rst, .reg_addr, .reg_wr_data,
      .reg_wr, .reg_rd, .reg_rd_data(rd_q), .wfi_exec, .halt_exec, .irq_pending(ev[0]),
      .time_base_irq(ev[1]), .active_halt_wake_irq(ev[2]), .halt_wake_irq(ev[3]),
      .reset_req(ev[4]), .core_clk_en, .periph_clk_en, .osc_enable, .time_base_clk_en(tb_en),
      .mask_force, .mask_force_value(mask_val), .irq_service, .cc_push,
      .reset_vector_fetch(rv_fetch), .watchdog_halt_block(wd_block), .mode_state);
   psm_cpu_model psm_cpu_model_inst (.ref_clk, .mask_force, .mask_force_value(mask_val),
      .cc_push, .irq_service, .reset_vector_fetch(rv_fetch), .wfi_exec, .halt_exec);
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic summarize;
      if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // the whole run is about 6000 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk("read data", e, rd_q);
   endtask : rd
   // hold wake lines until mode e shows, bounded; n is cycles taken
   task automatic wake(input logic [4:0] v, input logic [7:0] e, input int lim);
      @(posedge ref_clk);
      ev <= v;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (mode_state !== e && n < lim);
      chk("mode after wake", {24'h0, e}, {24'h0, mode_state});
      @(posedge ref_clk);
      ev <= 5'h00;
   endtask : wake
   task automatic settle(input int lo, input int hi);
      wake(5'h00, 8'h01, hi + 10);
      chk("settle span", 32'h1, {31'h0, n >= lo && n <= hi});
   endtask : settle
   task automatic enter(input logic halt, input logic [7:0] e);
      psm_cpu_model_inst.exec(halt);
      #1;
      chk("mode on entry", {24'h0, e}, {24'h0, mode_state});
   endtask : enter
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd(8'h04, 32'h01);
      rd(8'h00, 32'h0);
      rd(8'h08, 32'h0);
      enter(1'b0, 8'h04);
      repeat (2) @(posedge ref_clk);
      chk("cc mask", 32'h2, {30'h0, psm_cpu_model_inst.cc_mask});
      wake(5'h01, 8'h01, 20);
      for (k = 0; k < 4; k++) begin
         wr(8'h00, 32'h1 | (k << 1));
         rd(8'h04, 32'h02);
         n = 0;
         repeat (64) begin
            @(posedge ref_clk);
            #1;
            n += core_clk_en;
         end
         chk("slow ticks", 64 >> (k + 1), n);
      end
      enter(1'b0, 8'h08);
      n = 0;
      repeat (64) begin
         @(posedge ref_clk);
         #1;
         n += periph_clk_en;
      end
      chk("slow-wait ticks", 32'h4, n);
      wake(5'h01, 8'h02, 40);
      enter(1'b0, 8'h08);
      wake(5'h10, 8'h01, 40);
      wr(8'h00, 32'h08);
      enter(1'b1, 8'h10);
      chk("watchdog block", 32'h1, {31'h0, wd_block});
      @(posedge ref_clk);
      ev <= 5'h08;
      repeat (3) @(posedge ref_clk);
      ev <= 5'h00;
      #1;
      chk("mode held", 32'h10, {24'h0, mode_state});
      wake(5'h02, 8'h01, 20);
      chk("wake cycles", 32'h1, n);
      // software breaks the enable hold on purpose here
      wr(8'h00, 32'h0);
      wake(5'h00, 8'h80, 5);
      chk("osc in window", 32'h0, {31'h0, osc_enable});
      wake(5'h00, 8'h01, 300);
      wr(8'h00, 32'h08);
      enter(1'b1, 8'h10);
      wake(5'h04, 8'h01, 20);
      repeat (300) @(posedge ref_clk);
      @(posedge ref_clk);
      ev <= 5'h01;
      enter(1'b1, 8'h01);
      @(posedge ref_clk);
      ev <= 5'h00;
      enter(1'b1, 8'h10);
      wake(5'h10, 8'h40, 5);
      settle(250, 262);
      wr(8'h00, 32'h0);
      enter(1'b1, 8'h20);
      chk("osc in halt", 32'h0, {31'h0, osc_enable});
      wake(5'h08, 8'h40, 5);
      chk("osc restart", 32'h1, {31'h0, osc_enable});
      settle(250, 262);
      wr(8'h00, 32'h10);
      enter(1'b1, 8'h20);
      wake(5'h08, 8'h40, 5);
      settle(4090, 4102);
      exp_svc = 7;
      repeat (3) @(posedge ref_clk);
      chk("services", exp_svc, psm_cpu_model_inst.svc_count);
      chk("pushes", exp_svc, psm_cpu_model_inst.stack_q.size());
      chk("reset fetches", 32'h3, psm_cpu_model_inst.rst_count);
      summarize();
   end
endmodule : psm_power_mode_ctrl_bench
